// ===== logic/sac_pkg.sv
// constants, register map and state types of the converter control block
package sac_pkg;

  // register map
  localparam logic [7:0] SAC_RESULT_ADDR = 8'hD0;
  localparam logic [7:0] SAC_CTRL_ADDR = 8'hD1;

  // control register fields
  localparam int SAC_IRQ_EN_POS = 7;
  localparam int SAC_DONE_POS = 6;
  localparam int SAC_START_POS = 5;
  localparam int SAC_POWER_POS = 4;
  localparam logic [7:0] SAC_CTRL_RESET = 8'h40;
  localparam logic [7:0] SAC_RESULT_RESET = 8'h00;

  // timing: oscillator divided by twelve drives the sequencing
  localparam int SAC_CLK_DIV = 12;
  localparam int SAC_REF_OSC_KHZ = 8000;
  localparam int SAC_CONV_TIME_NS = 70000;
  // whole converter ticks in one conversion at the reference oscillator
  localparam int SAC_CONV_TICKS = (SAC_CONV_TIME_NS * SAC_REF_OSC_KHZ) / (SAC_CLK_DIV * 1000000);
  localparam int SAC_RES_BITS = 8;
  localparam int SAC_TICKS_PER_BIT = 5;
  localparam int SAC_SAMPLE_TICKS = SAC_CONV_TICKS - SAC_RES_BITS * SAC_TICKS_PER_BIT;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_BITS
  } sac_phase_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_req_t;

  // whole state of the controller
  typedef struct packed {
    sac_phase_t phase;
    logic [3:0] div_cnt;
    logic tick;
    logic [5:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] result;
    logic irq_en;
    logic done;
    logic power_on;
    logic busy;
    logic [7:0] rdata;
    logic irq;
    logic cmp_s1;
    logic cmp_s2;
  } sac_state_t;

endpackage

// ===== logic/sac_adc_ctrl.sv
// successive-approximation converter control with its two registers
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int DIV_RATIO = SAC_CLK_DIV
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire sac_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic cmp_in,
  output logic [7:0] dac_code,
  output logic analog_on,
  output logic conv_busy,
  output logic done_irq
);

  if (DIV_RATIO < 2 || DIV_RATIO > 16) begin : g_div_check
    $error("DIV_RATIO must lie in 2..16");
  end

  localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
  localparam logic [5:0] SAMPLE_LAST = 6'(SAC_SAMPLE_TICKS - 1);
  localparam logic [5:0] BIT_LAST = 6'(SAC_TICKS_PER_BIT - 1);

  sac_state_t s_r;
  sac_state_t s_nxt;

  logic ctrl_wr;
  logic start_wr;
  logic finish;

  function automatic logic [7:0] ctrl_view(input sac_state_t st);
    logic [7:0] v;
    v = 8'h00;
    v[SAC_IRQ_EN_POS] = st.irq_en;
    v[SAC_DONE_POS] = st.done;
    v[SAC_POWER_POS] = st.power_on;
    return v;
  endfunction

  assign ctrl_wr = bus_req.wr && (bus_req.addr == SAC_CTRL_ADDR);
  // a start only counts if the same write leaves the converter powered
  assign start_wr = ctrl_wr && bus_req.wdata[SAC_START_POS] && bus_req.wdata[SAC_POWER_POS];
  assign finish = (s_r.phase == SAC_BITS) && s_r.tick && (s_r.cnt == BIT_LAST) && (s_r.bit_idx == 3'h0);

  always_comb begin
    logic [7:0] t;
    t = s_r.trial;
    s_nxt = s_r;

    // comparator pin is asynchronous; only the second stage is read
    s_nxt.cmp_s1 = cmp_in;
    s_nxt.cmp_s2 = s_r.cmp_s1;

    // converter clock enable; nothing here looks at processor wait state
    s_nxt.tick = 1'b0;
    if (s_r.power_on) begin
      if (s_r.div_cnt == DIV_LAST) begin
        s_nxt.div_cnt = 4'h0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 4'h1;
      end
    end else begin
      s_nxt.div_cnt = 4'h0;
    end

    case (s_r.phase)
      SAC_IDLE: begin
        s_nxt.cnt = 6'h00;
      end
      SAC_SAMPLE: begin
        if (s_r.tick) begin
          if (s_r.cnt == SAMPLE_LAST) begin
            s_nxt.cnt = 6'h00;
            s_nxt.phase = SAC_BITS;
          end else begin
            s_nxt.cnt = s_r.cnt + 6'h01;
          end
        end
      end
      SAC_BITS: begin
        if (s_r.tick) begin
          if (s_r.cnt == BIT_LAST) begin
            // comparator low means input is below the trial level
            if (!s_r.cmp_s2) begin
              t[s_r.bit_idx] = 1'b0;
            end
            s_nxt.cnt = 6'h00;
            if (s_r.bit_idx == 3'h0) begin
              s_nxt.result = t;
              s_nxt.trial = t;
              s_nxt.phase = SAC_IDLE;
            end else begin
              t[s_r.bit_idx - 3'h1] = 1'b1;
              s_nxt.trial = t;
              s_nxt.bit_idx = s_r.bit_idx - 3'h1;
            end
          end else begin
            s_nxt.cnt = s_r.cnt + 6'h01;
          end
        end
      end
      default: begin
        s_nxt.phase = SAC_IDLE;
      end
    endcase

    if (ctrl_wr) begin
      s_nxt.irq_en = bus_req.wdata[SAC_IRQ_EN_POS];
      s_nxt.power_on = bus_req.wdata[SAC_POWER_POS];
      // the divider stops in the same cycle, so no stray tick follows power-down
      if (!bus_req.wdata[SAC_POWER_POS]) begin
        s_nxt.phase = SAC_IDLE;
        s_nxt.cnt = 6'h00;
        s_nxt.div_cnt = 4'h0;
        s_nxt.tick = 1'b0;
      end
    end

    // a start abandons whatever runs and resets the divider phase
    if (start_wr) begin
      s_nxt.phase = SAC_SAMPLE;
      s_nxt.cnt = 6'h00;
      s_nxt.div_cnt = 4'h0;
      s_nxt.tick = 1'b0;
      s_nxt.bit_idx = 3'(SAC_RES_BITS - 1);
      s_nxt.trial = 8'h80;
      s_nxt.done = 1'b0;
    end
    // completion in the same cycle as a start still sets done
    if (finish) begin
      s_nxt.done = 1'b1;
    end

    s_nxt.busy = (s_nxt.phase != SAC_IDLE);
    s_nxt.irq = s_nxt.done && s_nxt.irq_en;

    s_nxt.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == SAC_RESULT_ADDR) begin
        s_nxt.rdata = s_r.result;
      end else if (bus_req.addr == SAC_CTRL_ADDR) begin
        s_nxt.rdata = ctrl_view(s_r);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.irq_en <= SAC_CTRL_RESET[SAC_IRQ_EN_POS];
      s_r.done <= SAC_CTRL_RESET[SAC_DONE_POS];
      s_r.power_on <= SAC_CTRL_RESET[SAC_POWER_POS];
      s_r.result <= SAC_RESULT_RESET;
      s_r.phase <= SAC_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata = s_r.rdata;
  assign dac_code = s_r.trial;
  assign analog_on = s_r.power_on;
  assign conv_busy = s_r.busy;
  assign done_irq = s_r.irq;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  tick_spacing_a: assert property (s_r.tick |-> $past(s_r.div_cnt) == DIV_LAST)
    else $error("converter ticks closer than the divider allows");
  start_clears_done_a: assert property (start_wr && !finish |=> !s_r.done && s_r.phase == SAC_SAMPLE)
    else $error("start write did not clear done and begin sampling");
  finish_sets_done_a: assert property (finish |=> s_r.done)
    else $error("finished conversion without done flag");
  finish_idle_a: assert property (finish && !ctrl_wr |=> s_r.phase == SAC_IDLE && !conv_busy)
    else $error("converter kept running after its last bit");
  start_trial_a: assert property (start_wr |=> dac_code == 8'h80 && conv_busy)
    else $error("new conversion did not begin at mid-scale");
  idle_rdata_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data present without a read");
  no_self_start_a: assert property (s_r.phase == SAC_IDLE && !start_wr |=> s_r.phase == SAC_IDLE)
    else $error("conversion began without a start write");
  restart_busy_a: assert property (s_r.phase == SAC_BITS && start_wr |=> s_r.phase == SAC_SAMPLE && s_r.cnt == 6'h00)
    else $error("start during conversion did not restart");
  ctrl_read_a: assert property (bus_req.rd && bus_req.addr == SAC_CTRL_ADDR |=>
      bus_rdata[SAC_START_POS] == 1'b0 && bus_rdata[3:0] == 4'h0 && bus_rdata[SAC_DONE_POS] == $past(s_r.done))
    else $error("control readback wrong");
  irq_follow_a: assert property (s_r.done && s_r.irq_en |-> done_irq)
    else $error("done and enabled but no interrupt");
  done_hold_a: assert property (s_r.done && !start_wr |=> s_r.done)
    else $error("done flag dropped without a start");
  power_idle_a: assert property (!s_r.power_on |-> s_r.phase == SAC_IDLE && !s_r.tick)
    else $error("converter active while powered down");
  result_read_a: assert property (bus_req.rd && bus_req.addr == SAC_RESULT_ADDR |=> bus_rdata == $past(s_r.result))
    else $error("result readback wrong");
  result_stable_a: assert property (!finish |=> $stable(s_r.result))
    else $error("result changed outside completion");

endmodule

`default_nettype wire

// ===== tb/sac_analog_src.sv
// analog source and comparator seen by the converter
`timescale 1ns/1ps
`default_nettype none
module sac_analog_src (
  input wire logic [7:0] level,
  input wire logic [7:0] dac_code,
  input wire logic analog_on,
  output logic cmp_in
);
  // a single channel is selected, so one level feeds the comparator
  // unpowered comparator gives no usable answer, so it follows a changing pattern
  assign cmp_in = analog_on ? (level >= dac_code) : ^dac_code;
endmodule
`default_nettype wire

// ===== tb/sac_adc_ctrl_bench.sv
// register-level tests of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl_bench;
  import sac_pkg::*;
  // short divider keeps each conversion under a hundred cycles
  localparam int DIV = 2;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  sac_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata, dac_code, rd_val, prev;
  logic [7:0] level = 8'h00;
  logic cmp_in, analog_on, conv_busy, done_irq;
  logic [7:0] lv [6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h80, 8'h7F};
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int t0;
  sac_adc_ctrl #(.DIV_RATIO(DIV)) sac_adc_ctrl_inst (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .cmp_in(cmp_in), .dac_code(dac_code), .analog_on(analog_on), .conv_busy(conv_busy),
    .done_irq(done_irq));
  sac_analog_src sac_analog_src_inst (.level(level), .dac_code(dac_code), .analog_on(analog_on), .cmp_in(cmp_in));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard well above the thousand or so cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 rd_val = bus_rdata;
  endtask
  task automatic finish_conv(input logic [7:0] exp);
    int d;
    #1;
    for (int i = 0; i < 400 && conv_busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    d = cycles - t0;
    chk(8'(d >= (SAC_CONV_TICKS - 1) * DIV && d <= (SAC_CONV_TICKS + 1) * DIV + 4), 8'h01);
    rd(SAC_RESULT_ADDR);
    chk(rd_val, exp);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rd(SAC_CTRL_ADDR);
    chk(rd_val, SAC_CTRL_RESET);
    wr(SAC_CTRL_ADDR, 8'h2F);
    rd(SAC_CTRL_ADDR);
    chk(rd_val, 8'h40);
    wr(SAC_RESULT_ADDR, 8'h5A);
    rd(SAC_RESULT_ADDR);
    chk(rd_val, 8'h00);
    rd(8'hD2);
    chk(rd_val, 8'h00);
    // power comes up one access ahead of the first start
    wr(SAC_CTRL_ADDR, 8'h10);
    rd(SAC_CTRL_ADDR);
    chk(rd_val, 8'h50);
    prev = 8'h00;
    for (int i = 0; i < 6; i++) begin
      level <= lv[i];
      wr(SAC_CTRL_ADDR, 8'hB0);
      t0 = cycles;
      rd(SAC_CTRL_ADDR);
      chk(rd_val, 8'h90);
      chk(dac_code, 8'h80);
      chk({7'h00, done_irq}, 8'h00);
      rd(SAC_RESULT_ADDR);
      chk(rd_val, prev);
      finish_conv(lv[i]);
      chk({7'h00, done_irq}, 8'h01);
      rd(SAC_CTRL_ADDR);
      chk(rd_val, 8'hD0);
      prev = lv[i];
    end
    wr(SAC_CTRL_ADDR, 8'h10);
    repeat (200) @(posedge core_clk);
    #1 chk({7'h00, done_irq, conv_busy}, 8'h00);
    rd(SAC_CTRL_ADDR);
    chk(rd_val, 8'h50);
    // restart part way through: only the second level may land
    level <= 8'h33;
    wr(SAC_CTRL_ADDR, 8'h30);
    repeat (30) @(posedge core_clk);
    level <= 8'hC3;
    wr(SAC_CTRL_ADDR, 8'h30);
    t0 = cycles;
    finish_conv(8'hC3);
    chk({7'h00, done_irq}, 8'h00);
    wr(SAC_CTRL_ADDR, 8'h30);
    repeat (20) @(posedge core_clk);
    wr(SAC_CTRL_ADDR, 8'h00);
    #1 chk({6'h00, analog_on, conv_busy}, 8'h00);
    rd(SAC_RESULT_ADDR);
    chk(rd_val, 8'hC3);
    wr(SAC_CTRL_ADDR, 8'hB0);
    repeat (20) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk({6'h00, done_irq, conv_busy}, 8'h00);
    rd(SAC_CTRL_ADDR);
    chk(rd_val, SAC_CTRL_RESET);
    end_sim();
  end
endmodule
`default_nettype wire
